// ---- hdl/ifte_regs.svh ----
// Offsets, vectors and codes of the integer fault and trap exception unit
// Overview of operation
// RULE1: Write bus error raises access fault at once
// RULE2: Single read or first line beat faults immediately
// RULE3: Later line beat aborts; faults only if wanted
// RULE4: Prefetch bus error held until data used
// RULE5: Change of flow discards pending prefetch error; the code keeps it when a bus error also terminates in that cycle
// RULE6: Translation protection or residency fault raises access fault
// RULE7: Cache miss searches; bad search faults on retry
// RULE8: Wait for idle, take highest, drop lower
// RULE9: Access faults reported after pending instructions complete
// RULE10: Data fault aborts, waits for running prefetch
// RULE11: Access fault: copy status, supervisor, vector 2
// RULE12: Access frame: offset, status, pc, address, writebacks
// RULE13: Up to three pending write-backs are stacked
// RULE14: Double bus fault halts, status outputs 5
// RULE15: Halted: no memory activity until external reset
// RULE16: Odd prefetch: address error, no bus cycle
// RULE17: Other exceptions from completion go first
// RULE18: Address error uses vector 3, bit0 cleared
// RULE19: Address error inside fault processing halts
// RULE20: Trap vectors 5, 6, 7 by instruction
// RULE21: Unconditional trap vector is 32 plus n
// RULE22: Trap frame: next pc; trapping pc except unconditional
// RULE23: Vector address is base plus vector times four
`ifndef IFTE_REGS_SVH
`define IFTE_REGS_SVH
`define IFTE_REG_VBR    8'h00
`define IFTE_REG_STAT   8'h04
`define IFTE_REG_VEC    8'h08
`define IFTE_REG_FADDR  8'h0c
`define IFTE_VEC_AF     8'h02
`define IFTE_VEC_AE     8'h03
`define IFTE_VEC_DIV    8'h05
`define IFTE_VEC_CHK    8'h06
`define IFTE_VEC_CONDITIONAL_TRAP_INSTR 8'h07
`define IFTE_VEC_TRAPN  8'h20
`define IFTE_PST_RUN    4'h0
`define IFTE_PST_HALT   4'h5
`define IFTE_SR_T1      15
`define IFTE_SR_T0      14
`define IFTE_SR_S       13
`endif

// ---- hdl/ifte_pkg.sv ----
// Types of the integer fault and trap exception unit
package ifte_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_DRAIN, ST_STACK, ST_HALT} ifte_st_t;
  typedef enum logic [1:0] {CY_WRITE, CY_READ, CY_LINE, CY_FETCH} ifte_cyc_t;
  typedef enum logic [2:0] {TK_DIV, TK_CHK, TK_DUAL_BOUNDS_CHECK_INSTR, TK_CONDITIONAL_TRAP_INSTR, TK_FLOAT_CONDITIONAL_TRAP_INSTR,
                            TK_OVERFLOW_TRAP_INSTR, TK_TRAPN} ifte_trap_t;
  typedef enum logic [1:0] {EX_AF, EX_AE, EX_TRAP} ifte_ex_t;
  typedef struct packed {
    ifte_st_t    st;
    ifte_ex_t    ek;
    logic        af_pend;
    logic        af_data;
    logic [31:0] af_pc;
    logic [31:0] af_addr;
    logic        ae_pend;
    logic [31:0] ae_pc;
    logic [31:0] ae_addr;
    logic        tr_pend;
    logic        tr_has;
    logic [7:0]  tr_vec;
    logic [31:0] tr_pc;
    logic [31:0] tr_next;
    logic        pf_err;
    logic [31:0] pf_addr;
    logic        srch_bad;
    logic [31:0] vector_base_register;
    logic        wr_vbr;
    logic [31:0] rdata;
    logic        rdy;
    logic        resp;
    logic        start;
    logic        pf_go;
    logic        abort;
    logic        line_abort;
    logic        srch_req;
    logic        freeze;
    logic        sdata;
    logic [7:0]  vnum;
    logic [31:0] vaddr;
    logic [9:0]  vofs;
    logic [15:0] fr_sr;
    logic [15:0] new_sr;
    logic [31:0] fr_pc;
    logic [31:0] fr_addr;
    logic        fr_has;
    logic [1:0]  fr_wb;
    logic        halt;
    logic [3:0]  pst;
  } ifte_state_t;
endpackage

// ---- hdl/ifte_unit.sv ----
// Integer fault and trap exception unit with AHB-Lite register slave
//
// Decided for this implementation: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ifte_regs.svh"
module ifte_unit (
  input  wire logic        REF_CLK_I,
  input  wire logic        NRST_I,
  input  wire logic        HSEL_I,
  input  wire logic [31:0] HADDR_I,
  input  wire logic [1:0]  HTRANS_I,
  input  wire logic        HWRITE_I,
  input  wire logic [2:0]  HSIZE_I,
  input  wire logic [31:0] HWDATA_I,
  input  wire logic        HREADY_I,
  output logic      [31:0] HRDATA_O,
  output logic             HREADYOUT_O,
  output logic             HRESP_O,
  input  wire logic [15:0] STATUS_WORD_I,
  input  wire logic [31:0] EXEC_PC_I,
  input  wire logic        BUS_ERROR_INPUT_I,
  input  wire logic        CYC_DONE_I,
  input  wire logic [1:0]  CYC_KIND_I,
  input  wire logic [1:0]  CYC_BEAT_I,
  input  wire logic        CYC_WANTED_I,
  input  wire logic [31:0] CYC_ADDR_I,
  input  wire logic        PF_REQ_I,
  input  wire logic [31:0] PF_ADDR_I,
  input  wire logic        PF_USE_I,
  input  wire logic        FLOW_CHANGE_I,
  input  wire logic        XLAT_FAULT_I,
  input  wire logic        XLAT_DATA_I,
  input  wire logic [31:0] XLAT_ADDR_I,
  input  wire logic        ATC_MISS_I,
  input  wire logic        SEARCH_DONE_I,
  input  wire logic        SEARCH_BAD_I,
  input  wire logic        RETRY_I,
  input  wire logic        TRAP_I,
  input  wire logic [2:0]  TRAP_KIND_I,
  input  wire logic [3:0]  TRAP_N_I,
  input  wire logic [31:0] TRAP_PC_I,
  input  wire logic [31:0] NEXT_PC_I,
  input  wire logic        PIPE_IDLE_I,
  input  wire logic        PENDING_DONE_I,
  input  wire logic        PF_BUSY_I,
  input  wire logic [1:0]  WB_PENDING_I,
  input  wire logic        STACK_DONE_I,
  input  wire logic        RTE_LOAD_I,
  input  wire logic        RESET_SEQ_I,
  output logic             PF_GO_O,
  output logic             ABORT_O,
  output logic             LINE_ABORT_O,
  output logic             SEARCH_REQ_O,
  output logic             FREEZE_O,
  output logic             EXC_START_O,
  output logic      [7:0]  VEC_NUM_O,
  output logic      [31:0] VEC_ADDR_O,
  output logic             VEC_SUPER_DATA_O,
  output logic      [9:0]  FRAME_VOFS_O,
  output logic      [15:0] FRAME_SR_O,
  output logic      [15:0] NEW_STATUS_WORD_O,
  output logic      [31:0] FRAME_PC_O,
  output logic      [31:0] FRAME_ADDR_O,
  output logic             FRAME_ADDR_VALID_O,
  output logic      [1:0]  FRAME_WB_CNT_O,
  output logic             HALT_O,
  output logic      [3:0]  PROCESSOR_STATUS_OUTPUTS_O
);

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [9:0] vec_ofs(input logic [7:0] v);
    vec_ofs = {v, 2'b00};
  endfunction

  function automatic logic [31:0] vec_adr(input logic [31:0] b, input logic [7:0] v);
    vec_adr = b + {22'h0, vec_ofs(v)};
  endfunction

  function automatic logic [15:0] sup_sr(input logic [15:0] sr);
    logic [15:0] r;
    r = sr;
    r[`IFTE_SR_T1] = 1'b0;
    r[`IFTE_SR_T0] = 1'b0;
    r[`IFTE_SR_S] = 1'b1;
    sup_sr = r;
  endfunction

  function automatic logic [7:0] trap_vec(input ifte_pkg::ifte_trap_t k, input logic [3:0] tn);
    case (k)
      ifte_pkg::TK_DIV:  trap_vec = `IFTE_VEC_DIV;
      ifte_pkg::TK_CHK,
      ifte_pkg::TK_DUAL_BOUNDS_CHECK_INSTR: trap_vec = `IFTE_VEC_CHK;
      ifte_pkg::TK_TRAPN: trap_vec = `IFTE_VEC_TRAPN + {4'h0, tn};
      default:           trap_vec = `IFTE_VEC_CONDITIONAL_TRAP_INSTR;
    endcase
  endfunction

  // ****************************************
  // State
  // ****************************************
  ifte_pkg::ifte_state_t state_ff;
  ifte_pkg::ifte_state_t nxt_state;
  ifte_pkg::ifte_cyc_t   cyc;
  ifte_pkg::ifte_trap_t  tk;
  logic                  berr;
  logic                  take_ok;
  logic                  bus_acc;
  logic                  dbl;
  logic [7:0]            v;
  logic [7:0]            ra;

  always_comb begin
    nxt_state = state_ff;
    cyc = ifte_pkg::ifte_cyc_t'(CYC_KIND_I);
    tk = ifte_pkg::ifte_trap_t'(TRAP_KIND_I);
    berr = BUS_ERROR_INPUT_I && CYC_DONE_I;
    v = `IFTE_VEC_AE;
    ra = HADDR_I[7:0];
    nxt_state.start = 1'b0;
    nxt_state.pf_go = 1'b0;
    nxt_state.abort = 1'b0;
    nxt_state.line_abort = 1'b0;
    nxt_state.srch_req = 1'b0;
    nxt_state.rdy = 1'b1;
    nxt_state.resp = 1'b0;

    // ****************************************
    // Register slave, zero wait states
    // ****************************************
    bus_acc = HSEL_I && HREADY_I && HTRANS_I[1];
    nxt_state.wr_vbr = bus_acc && HWRITE_I && HADDR_I[31:0] == {24'h0, `IFTE_REG_VBR};
    if (state_ff.wr_vbr) begin
      nxt_state.vector_base_register = HWDATA_I;
    end
    if (bus_acc && !HWRITE_I) begin
      nxt_state.rdata = 32'h0;
      if (HADDR_I[31:8] == 24'h0) begin
        case (ra)
          `IFTE_REG_VBR:   nxt_state.rdata = state_ff.wr_vbr ? HWDATA_I : state_ff.vector_base_register;
          `IFTE_REG_STAT:  nxt_state.rdata = {24'h0, state_ff.halt, state_ff.srch_bad,
                                              state_ff.pf_err, state_ff.tr_pend,
                                              state_ff.ae_pend, state_ff.af_pend,
                                              state_ff.st};
          `IFTE_REG_VEC:   nxt_state.rdata = {24'h0, state_ff.vnum};
          `IFTE_REG_FADDR: nxt_state.rdata = state_ff.fr_addr;
          default:         nxt_state.rdata = 32'h0;
        endcase
      end
    end

    // ****************************************
    // Sequencing
    // ****************************************
    take_ok = PIPE_IDLE_I && PENDING_DONE_I               // RULE8 RULE9
              && !(state_ff.af_data && PF_BUSY_I);        // RULE10
    dbl = 1'b0;
    case (state_ff.st)
      ifte_pkg::ST_RUN: begin
      end
      ifte_pkg::ST_DRAIN: begin
        if (take_ok) begin
          // Trap from completing work beats faults
          if (state_ff.tr_pend) begin                     // RULE17
            v = state_ff.tr_vec;                          // RULE20 RULE21
            nxt_state.ek = ifte_pkg::EX_TRAP;
            nxt_state.fr_pc = state_ff.tr_next;           // RULE22
            nxt_state.fr_addr = state_ff.tr_pc;
            nxt_state.fr_has = state_ff.tr_has;
            nxt_state.fr_wb = 2'h0;
          end else if (state_ff.af_pend) begin
            v = `IFTE_VEC_AF;                             // RULE11
            nxt_state.ek = ifte_pkg::EX_AF;
            nxt_state.fr_pc = state_ff.af_pc;             // RULE12
            nxt_state.fr_addr = state_ff.af_addr;
            nxt_state.fr_has = 1'b1;
            nxt_state.fr_wb = WB_PENDING_I;               // RULE13
          end else begin
            v = `IFTE_VEC_AE;                             // RULE18
            nxt_state.ek = ifte_pkg::EX_AE;
            nxt_state.fr_pc = state_ff.ae_pc;
            nxt_state.fr_addr = {state_ff.ae_addr[31:1], 1'b0};
            nxt_state.fr_has = 1'b1;
            nxt_state.fr_wb = 2'h0;
          end
          // Lower ones come back through restart
          nxt_state.tr_pend = 1'b0;                       // RULE8
          nxt_state.af_pend = 1'b0;
          nxt_state.af_data = 1'b0;
          nxt_state.ae_pend = 1'b0;
          nxt_state.vnum = v;
          nxt_state.vofs = vec_ofs(v);
          nxt_state.vaddr = vec_adr(state_ff.vector_base_register, v);     // RULE23
          nxt_state.sdata = 1'b1;
          nxt_state.fr_sr = STATUS_WORD_I;
          nxt_state.new_sr = sup_sr(STATUS_WORD_I);       // RULE11 RULE20
          nxt_state.start = 1'b1;
          nxt_state.st = ifte_pkg::ST_STACK;
        end
      end
      ifte_pkg::ST_STACK: begin
        // Bus or address error while stacking a fault
        dbl = state_ff.ek != ifte_pkg::EX_TRAP
              && (berr || (PF_REQ_I && PF_ADDR_I[0]));    // RULE14 RULE19
        if (STACK_DONE_I) begin
          nxt_state.st = ifte_pkg::ST_RUN;
          nxt_state.sdata = 1'b0;
        end
      end
      ifte_pkg::ST_HALT: begin
      end
      default: nxt_state.st = ifte_pkg::ST_RUN;
    endcase
    if ((RTE_LOAD_I || RESET_SEQ_I) && (berr || (PF_REQ_I && PF_ADDR_I[0]))) begin
      dbl = 1'b1;                                         // RULE14 RULE19
    end

    // ****************************************
    // Event capture, set wins over take
    // ****************************************
    if (state_ff.st == ifte_pkg::ST_RUN || state_ff.st == ifte_pkg::ST_DRAIN) begin
      if (berr) begin
        case (cyc)
          ifte_pkg::CY_WRITE,
          ifte_pkg::CY_READ: begin
            nxt_state.af_pend = 1'b1;                     // RULE1 RULE2
            nxt_state.af_data = 1'b1;
            nxt_state.af_addr = CYC_ADDR_I;
            nxt_state.af_pc = EXEC_PC_I;
            nxt_state.abort = 1'b1;                       // RULE10
          end
          ifte_pkg::CY_LINE: begin
            nxt_state.line_abort = CYC_BEAT_I != 2'h0;    // RULE3
            if (CYC_BEAT_I == 2'h0 || CYC_WANTED_I) begin
              nxt_state.af_pend = 1'b1;                   // RULE2 RULE3
              nxt_state.af_data = 1'b1;
              nxt_state.af_addr = CYC_ADDR_I;
              nxt_state.af_pc = EXEC_PC_I;
              nxt_state.abort = 1'b1;
            end
          end
          default: begin
            nxt_state.pf_err = 1'b1;                      // RULE4
            nxt_state.pf_addr = CYC_ADDR_I;
          end
        endcase
      end else if (FLOW_CHANGE_I) begin
        nxt_state.pf_err = 1'b0;                          // RULE5
      end
      if (PF_USE_I && state_ff.pf_err && !FLOW_CHANGE_I) begin
        nxt_state.pf_err = berr && cyc == ifte_pkg::CY_FETCH; // RULE4
        nxt_state.af_pend = 1'b1;
        nxt_state.af_addr = state_ff.pf_addr;
        nxt_state.af_pc = EXEC_PC_I;
      end
      if (XLAT_FAULT_I) begin
        nxt_state.af_pend = 1'b1;                         // RULE6
        nxt_state.af_data = nxt_state.af_data || XLAT_DATA_I;
        nxt_state.af_addr = XLAT_ADDR_I;
        nxt_state.af_pc = EXEC_PC_I;
        nxt_state.abort = nxt_state.abort || XLAT_DATA_I;
      end
      nxt_state.srch_req = ATC_MISS_I;                    // RULE7
      if (SEARCH_DONE_I) begin
        nxt_state.srch_bad = SEARCH_BAD_I;
      end
      if (RETRY_I && state_ff.srch_bad) begin
        nxt_state.srch_bad = SEARCH_DONE_I && SEARCH_BAD_I; // RULE7
        nxt_state.af_pend = 1'b1;
        nxt_state.af_addr = XLAT_ADDR_I;
        nxt_state.af_pc = EXEC_PC_I;
      end
      if (PF_REQ_I) begin
        if (PF_ADDR_I[0]) begin
          nxt_state.ae_pend = 1'b1;                       // RULE16
          nxt_state.ae_addr = PF_ADDR_I;
          nxt_state.ae_pc = EXEC_PC_I;
        end else begin
          nxt_state.pf_go = 1'b1;
        end
      end
      if (TRAP_I) begin
        nxt_state.tr_pend = 1'b1;                         // RULE20
        nxt_state.tr_vec = trap_vec(tk, TRAP_N_I);        // RULE21
        nxt_state.tr_has = tk != ifte_pkg::TK_TRAPN;      // RULE22
        nxt_state.tr_pc = TRAP_PC_I;
        nxt_state.tr_next = NEXT_PC_I;
      end
      if (state_ff.st == ifte_pkg::ST_RUN
          && (nxt_state.af_pend || nxt_state.ae_pend || nxt_state.tr_pend)) begin
        nxt_state.st = ifte_pkg::ST_DRAIN;                // RULE8
      end
    end

    // ****************************************
    // Halt on double bus fault or address error in fault processing
    // ****************************************
    if (dbl || state_ff.st == ifte_pkg::ST_HALT) begin
      nxt_state.st = ifte_pkg::ST_HALT;                   // RULE15
      nxt_state.halt = 1'b1;
      nxt_state.pst = `IFTE_PST_HALT;                     // RULE14
      nxt_state.pf_go = 1'b0;
      nxt_state.abort = 1'b0;
      nxt_state.srch_req = 1'b0;
      nxt_state.start = 1'b0;
      nxt_state.sdata = 1'b0;
    end else begin
      nxt_state.pst = `IFTE_PST_RUN;
    end
    nxt_state.freeze = nxt_state.st != ifte_pkg::ST_RUN;
  end

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign HRDATA_O = state_ff.rdata;
  assign HREADYOUT_O = state_ff.rdy;
  assign HRESP_O = state_ff.resp;
  assign PF_GO_O = state_ff.pf_go;
  assign ABORT_O = state_ff.abort;
  assign LINE_ABORT_O = state_ff.line_abort;
  assign SEARCH_REQ_O = state_ff.srch_req;
  assign FREEZE_O = state_ff.freeze;
  assign EXC_START_O = state_ff.start;
  assign VEC_NUM_O = state_ff.vnum;
  assign VEC_ADDR_O = state_ff.vaddr;
  assign VEC_SUPER_DATA_O = state_ff.sdata;
  assign FRAME_VOFS_O = state_ff.vofs;
  assign FRAME_SR_O = state_ff.fr_sr;
  assign NEW_STATUS_WORD_O = state_ff.new_sr;
  assign FRAME_PC_O = state_ff.fr_pc;
  assign FRAME_ADDR_O = state_ff.fr_addr;
  assign FRAME_ADDR_VALID_O = state_ff.fr_has;
  assign FRAME_WB_CNT_O = state_ff.fr_wb;
  assign HALT_O = state_ff.halt;
  assign PROCESSOR_STATUS_OUTPUTS_O = state_ff.pst;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);

  logic running;
  assign running = state_ff.st == ifte_pkg::ST_RUN;

  property p_write_fault;
    running && berr && CYC_KIND_I == 2'h0 && !RTE_LOAD_I && !RESET_SEQ_I
      |=> state_ff.af_pend && ABORT_O ##1 !ABORT_O || EXC_START_O || HALT_O;
  endproperty
  a_write_fault: assert property (p_write_fault) else $error("write error lost"); // RULE1

  property p_line_late;
    running && berr && CYC_KIND_I == 2'h2 && CYC_BEAT_I != 2'h0 && !CYC_WANTED_I
      && !state_ff.af_pend && !XLAT_FAULT_I && !RETRY_I && !PF_USE_I && !dbl
      |=> LINE_ABORT_O && !state_ff.af_pend;
  endproperty
  a_line_late: assert property (p_line_late) else $error("late beat mishandled"); // RULE3

  property p_pf_defer;
    running && berr && CYC_KIND_I == 2'h3 && !dbl |=> state_ff.pf_err && !ABORT_O;
  endproperty
  a_pf_defer: assert property (p_pf_defer) else $error("prefetch error not held"); // RULE4

  property p_flow_clear;
    running && FLOW_CHANGE_I && !berr && !dbl |=> !state_ff.pf_err;
  endproperty
  a_flow_clear: assert property (p_flow_clear) else $error("stale prefetch error"); // RULE5

  property p_odd_fetch;
    running && PF_REQ_I && PF_ADDR_I[0] && !dbl |=> !PF_GO_O && state_ff.ae_pend;
  endproperty
  a_odd_fetch: assert property (p_odd_fetch) else $error("odd prefetch ran"); // RULE16

  property p_halt_code;
    HALT_O |-> PROCESSOR_STATUS_OUTPUTS_O == 4'h5 && !PF_GO_O && !EXC_START_O;
  endproperty
  a_halt_code: assert property (p_halt_code) else $error("bad halt status"); // RULE14

  property p_halt_stays;
    HALT_O |=> HALT_O [*8];
  endproperty
  a_halt_stays: assert property (p_halt_stays) else $error("left halt"); // RULE15

  property p_wait_idle;
    $rose(EXC_START_O) |-> $past(PIPE_IDLE_I) && $past(PENDING_DONE_I);
  endproperty
  a_wait_idle: assert property (p_wait_idle) else $error("taken before idle"); // RULE8

  property p_sr_fix;
    EXC_START_O |-> !NEW_STATUS_WORD_O[15] && !NEW_STATUS_WORD_O[14]
      && NEW_STATUS_WORD_O[13] && FRAME_SR_O[12:0] == NEW_STATUS_WORD_O[12:0];
  endproperty
  a_sr_fix: assert property (p_sr_fix) else $error("status copy wrong"); // RULE11

  property p_vec_addr;
    EXC_START_O |-> VEC_ADDR_O == state_ff.vector_base_register + {22'h0, VEC_NUM_O, 2'b00}
      && FRAME_VOFS_O == {VEC_NUM_O, 2'b00} && VEC_SUPER_DATA_O;
  endproperty
  a_vec_addr: assert property (p_vec_addr) else $error("vector address wrong"); // RULE23

  property p_ae_frame;
    EXC_START_O && VEC_NUM_O == 8'h03 |-> !FRAME_ADDR_O[0] && FRAME_ADDR_VALID_O;
  endproperty
  a_ae_frame: assert property (p_ae_frame) else $error("odd address kept"); // RULE18

  property p_trapn;
    running && TRAP_I && TRAP_KIND_I == 3'h6 && !dbl |=> state_ff.tr_vec == 8'h20 + {4'h0,
      $past(TRAP_N_I)} && !state_ff.tr_has;
  endproperty
  a_trapn: assert property (p_trapn) else $error("trap n vector wrong"); // RULE21

endmodule // ifte_unit
`default_nettype wire

// ---- testbench/ifte_bus_model.sv ----
// Far-side bus model that terminates cycles with a transfer error
`timescale 1ns/1ps
`default_nettype none
module ifte_bus_model (
  input  wire logic        clk_i,
  input  wire logic        req_i,
  input  wire logic [1:0]  kind_i,
  input  wire logic [1:0]  beat_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [2:0]  lat_i,
  output logic             done_o,
  output logic             err_o,
  output logic      [1:0]  kind_o,
  output logic      [1:0]  beat_o,
  output logic      [31:0] addr_o
);
  // ****************************************
  // Termination after a chosen latency
  // ****************************************
  logic [3:0]  cnt_ff = 4'h0;
  logic [31:0] addr_q = 32'h0;
  initial begin
    done_o = 1'b0;
    err_o = 1'b0;
    kind_o = 2'h0;
    beat_o = 2'h0;
    addr_o = 32'h0;
  end
  always @(posedge clk_i) begin
    done_o <= (cnt_ff == 4'h1);
    // Error and address lines carry junk outside a termination
    err_o <= (cnt_ff == 4'h1) ? 1'b1 : ~err_o;
    addr_o <= (cnt_ff == 4'h1) ? addr_q : ~addr_o;
    if (req_i) begin
      cnt_ff <= {1'b0, lat_i} + 4'h1;
      kind_o <= kind_i;
      beat_o <= beat_i;
      addr_q <= addr_i;
    end else if (cnt_ff != 4'h0) begin
      cnt_ff <= cnt_ff - 4'h1;
    end
  end
endmodule // ifte_bus_model
`default_nettype wire

// ---- testbench/integer_fault_trap_exception_unit_tb_top.sv ----
// Self-checking bench for the fault and trap exception unit
`timescale 1ns/1ps
`default_nettype none
module integer_fault_trap_exception_unit_tb_top;
  logic        REF_CLK_I = 1'b0, NRST_I = 1'b0, HSEL_I = 1'b1, HWRITE_I = 1'b0;
  logic [1:0]  HTRANS_I = 2'h0, WB_PENDING_I = 2'h3, CYC_KIND_I, CYC_BEAT_I, FRAME_WB_CNT_O;
  logic [2:0]  HSIZE_I = 3'h2, TRAP_KIND_I = 3'h0, lat = 3'h0;
  logic [3:0]  TRAP_N_I = 4'h9, PROCESSOR_STATUS_OUTPUTS_O;
  logic [15:0] STATUS_WORD_I = 16'hc0a5, FRAME_SR_O, NEW_STATUS_WORD_O;
  logic [31:0] HADDR_I = 32'h0, HWDATA_I = 32'h0, EXEC_PC_I = 32'h100, PF_ADDR_I = 32'h0;
  logic [31:0] XLAT_ADDR_I = 32'h4000, TRAP_PC_I = 32'h204, NEXT_PC_I = 32'h206, CYC_ADDR_I;
  logic [31:0] HRDATA_O, VEC_ADDR_O, FRAME_PC_O, FRAME_ADDR_O, vector_base_register = 32'h0, rd, a_q = 32'h0;
  logic        CYC_WANTED_I = 1'b0, XLAT_DATA_I = 1'b1, SEARCH_BAD_I = 1'b1, PIPE_IDLE_I = 1'b1;
  logic        PENDING_DONE_I = 1'b1, PF_BUSY_I = 1'b0, STACK_DONE_I = 1'b0, RTE_LOAD_I = 1'b0;
  logic        RESET_SEQ_I = 1'b0, CYC_DONE_I, BUS_ERROR_INPUT_I, HREADYOUT_O, HRESP_O, PF_GO_O;
  logic        ABORT_O, LINE_ABORT_O, SEARCH_REQ_O, FREEZE_O, EXC_START_O, VEC_SUPER_DATA_O;
  logic        FRAME_ADDR_VALID_O, HALT_O, req = 1'b0;
  logic [1:0]  kind = 2'h0, beat = 2'h0;
  logic [7:0]  ev = 8'h0, VEC_NUM_O;
  logic [9:0]  FRAME_VOFS_O;
  logic [7:0]  tv [7] = '{8'h05, 8'h06, 8'h06, 8'h07, 8'h07, 8'h07, 8'h29};
  int          errors = 0, compares = 0, nstart = 0, ngo = 0, n0, nab = 0, nla = 0, nsr = 0;
  wire         HREADY_I = HREADYOUT_O;
  wire         PF_REQ_I = ev[0], PF_USE_I = ev[1], FLOW_CHANGE_I = ev[2], XLAT_FAULT_I = ev[3];
  wire         ATC_MISS_I = ev[4], SEARCH_DONE_I = ev[5], RETRY_I = ev[6], TRAP_I = ev[7];

  ifte_unit DUT (.*);
  ifte_bus_model u_bus (.clk_i(REF_CLK_I), .req_i(req), .kind_i(kind), .beat_i(beat),
    .addr_i(a_q), .lat_i(lat), .done_o(CYC_DONE_I), .err_o(BUS_ERROR_INPUT_I),
    .kind_o(CYC_KIND_I), .beat_o(CYC_BEAT_I), .addr_o(CYC_ADDR_I));

  always #50 REF_CLK_I = ~REF_CLK_I;
  always @(negedge REF_CLK_I) begin
    nstart += (EXC_START_O === 1'b1);
    ngo += (PF_GO_O === 1'b1);
    nab += (ABORT_O === 1'b1);
    nla += (LINE_ABORT_O === 1'b1);
    nsr += (SEARCH_REQ_O === 1'b1);
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic tk(input int n);
    repeat (n) @(posedge REF_CLK_I);
  endtask
  task automatic chk(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      errors++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic hw;
    do begin
      @(posedge REF_CLK_I);
    end while (HREADY_I !== 1'b1);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    @(posedge REF_CLK_I);
    HTRANS_I <= 2'h2;
    HADDR_I <= a;
    HWRITE_I <= w;
    hw();
    HTRANS_I <= 2'h0;
    HWDATA_I <= wd;
    hw();
    rd = HRDATA_O;
  endtask
  task automatic pulse(input logic [7:0] m);
    @(posedge REF_CLK_I);
    ev <= m;
    @(posedge REF_CLK_I);
    ev <= 8'h0;
  endtask
  task automatic bus(input logic [1:0] k, input logic [1:0] b, input logic w,
                     input logic [31:0] a, input logic [2:0] l);
    @(posedge REF_CLK_I);
    req <= 1'b1;
    kind <= k;
    beat <= b;
    CYC_WANTED_I <= w;
    a_q <= a;
    lat <= l;
    @(posedge REF_CLK_I);
    req <= 1'b0;
  endtask
  task automatic quiet;
    int s;
    s = nstart;
    tk(10);
    chk(nstart == s, "unexpected exception");
  endtask
  task automatic take(input logic [7:0] v, input logic [31:0] pc, input logic [31:0] fa,
                      input logic ha);
    int i;
    i = 0;
    while (EXC_START_O !== 1'b1 && i < 30) begin
      @(posedge REF_CLK_I);
      #1;
      i++;
    end
    chk(EXC_START_O === 1'b1 && VEC_NUM_O === v && FREEZE_O === 1'b1, "vector number");
    chk(VEC_ADDR_O === vector_base_register + {22'h0, v, 2'b00} && VEC_SUPER_DATA_O === 1'b1, "vec addr");
    chk(NEW_STATUS_WORD_O === 16'h20a5 && FRAME_SR_O === 16'hc0a5, "status");
    chk(FRAME_VOFS_O === {v, 2'b00} && FRAME_PC_O === pc, "frame pc");
    chk(FRAME_ADDR_VALID_O === ha && (!ha || FRAME_ADDR_O === fa), "frame addr");
  endtask
  task automatic sd;
    @(posedge REF_CLK_I);
    STACK_DONE_I <= 1'b1;
    @(posedge REF_CLK_I);
    STACK_DONE_I <= 1'b0;
    tk(2);
  endtask
  task automatic finish_test;
    if (errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    tk(5000);
    errors++;
    finish_test();
  end

  initial begin
    tk(8);
    NRST_I <= 1'b1;
    tk(2);
    ahb(1'b1, 32'h0, 32'h1000);
    vector_base_register = 32'h1000;
    ahb(1'b0, 32'h0, 32'h0);
    chk(rd === 32'h1000 && HRESP_O === 1'b0, "base readback");
    ahb(1'b0, 32'h10, 32'h0);
    chk(rd === 32'h0, "unmapped read");
    PENDING_DONE_I <= 1'b0;
    PF_BUSY_I <= 1'b1;
    bus(2'h0, 2'h0, 1'b0, 32'h2000, 3'h4);
    quiet();
    PENDING_DONE_I <= 1'b1;
    quiet();
    PF_BUSY_I <= 1'b0;
    take(8'h02, 32'h100, 32'h2000, 1'b1);
    chk(FRAME_WB_CNT_O === 2'h3, "write-backs");
    chk(nab == 1, "abort");
    sd();
    for (int k = 0; k < 4; k++) begin
      bus(k == 0 ? 2'h1 : 2'h2, k < 2 ? 2'h0 : 2'h2, k != 3, 32'h2100, k[2:0]);
      if (k < 3) begin
        take(8'h02, 32'h100, 32'h2100, 1'b1);
        sd();
      end else begin
        quiet();
        chk(nla == 2, "line abort");
      end
    end
    bus(2'h3, 2'h0, 1'b0, 32'h3000, 3'h0);
    quiet();
    pulse(8'h04);
    pulse(8'h02);
    quiet();
    bus(2'h3, 2'h0, 1'b0, 32'h3000, 3'h1);
    tk(4);
    pulse(8'h02);
    take(8'h02, 32'h100, 32'h3000, 1'b1);
    sd();
    n0 = ngo;
    PF_ADDR_I <= 32'h3000;
    pulse(8'h01);
    tk(2);
    PF_ADDR_I <= 32'h3001;
    pulse(8'h01);
    tk(2);
    chk(ngo == n0 + 1, "prefetch go");
    take(8'h03, 32'h100, 32'h3000, 1'b1);
    sd();
    for (int k = 0; k < 7; k++) begin
      TRAP_KIND_I <= k[2:0];
      pulse(8'h80);
      take(tv[k], 32'h206, 32'h204, k != 6);
      sd();
    end
    TRAP_KIND_I <= 3'h0;
    pulse(8'h81);
    take(8'h05, 32'h206, 32'h204, 1'b1);
    sd();
    quiet();
    pulse(8'h08);
    take(8'h02, 32'h100, 32'h4000, 1'b1);
    sd();
    pulse(8'h10);
    pulse(8'h20);
    pulse(8'h40);
    take(8'h02, 32'h100, 32'h4000, 1'b1);
    sd();
    chk(nsr == 1, "search");
    SEARCH_BAD_I <= 1'b0;
    pulse(8'h20);
    pulse(8'h40);
    quiet();
    bus(2'h0, 2'h0, 1'b0, 32'h2000, 3'h0);
    take(8'h02, 32'h100, 32'h2000, 1'b1);
    bus(2'h0, 2'h0, 1'b0, 32'h2000, 3'h0);
    tk(4);
    chk(HALT_O === 1'b1 && PROCESSOR_STATUS_OUTPUTS_O === 4'h5, "double fault");
    n0 = ngo;
    PF_ADDR_I <= 32'h3000;
    pulse(8'h01);
    tk(4);
    chk(ngo == n0 && HALT_O === 1'b1, "halted activity");
    NRST_I <= 1'b0;
    tk(2);
    NRST_I <= 1'b1;
    vector_base_register = 32'h0;
    tk(2);
    chk(HALT_O === 1'b0 && PROCESSOR_STATUS_OUTPUTS_O === 4'h0, "reset leaves halt");
    PF_ADDR_I <= 32'h3001;
    pulse(8'h01);
    take(8'h03, 32'h100, 32'h3000, 1'b1);
    pulse(8'h01);
    tk(4);
    chk(HALT_O === 1'b1 && PROCESSOR_STATUS_OUTPUTS_O === 4'h5, "odd in stacking");
    NRST_I <= 1'b0;
    tk(2);
    NRST_I <= 1'b1;
    RTE_LOAD_I <= 1'b1;
    bus(2'h1, 2'h0, 1'b0, 32'h2000, 3'h0);
    tk(4);
    chk(HALT_O === 1'b1, "return load fault");
    finish_test();
  end
endmodule // integer_fault_trap_exception_unit_tb_top
`default_nettype wire
